// ### design/cis_speed_select.sv
`timescale 1ns/10ps
module cis_speed_select #(
   parameter int SAMPLE_CYCLES = cis_pkg::SAMPLE_CYC,
   parameter int MS_CYCLES = cis_pkg::CYC_PER_MS
) (
   input wire logic i_clk, // 10 MHz clock
   input wire logic i_resetn, // synchronous reset, low
   input wire logic [3:0] i_addr, // register address
   input wire logic [15:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [15:0] o_rdata, // read data, cycle after i_rd
   input wire logic i_speed_select_a_n, // select A, low = on
   input wire logic i_speed_select_b_n, // select B, low = on
   input wire logic i_direction_select_n, // direction, low = reverse
   input wire logic i_ref_pulse, // pulse reference input
   input wire logic i_positioning_done_n, // positioning done, low = done
   output logic [15:0] o_speed_ref, // ramped speed magnitude, rpm
   output logic o_reverse, // 1 = reverse rotation
   output logic [1:0] o_source, // active reference source
   output logic o_ref_pulse, // accepted reference pulse
   output logic o_fwd_limit_en, // forward torque limit enable
   output logic o_rev_limit_en, // reverse torque limit enable
   output logic o_alt_func // direction input alternative function
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] accel_r, decel_r, spd1_r, spd2_r, spd3_r, max_r;
   logic [6:0] ctrl_r;
   logic [15:0] rdata_r;
   logic [1:0] sel_r; // sampled selects, bit1 = A, bit0 = B
   logic [31:0] samp_cnt_r;
   logic [31:0] ms_cnt_r;
   logic [15:0] ref_r;
   logic rev_r;
   logic [1:0] src_r;
   logic hold_pulse_r;
   logic pulse_r;
   cis_pkg::cis_alt_s alt_r;
   ////////////////////////////////////////////////////////////////////////
   wire [3:0] mode = ctrl_r[cis_pkg::CTRL_MODE_LSB +: 4];
   wire allocated = ctrl_r[cis_pkg::CTRL_ALLOC_A] &
                    ctrl_r[cis_pkg::CTRL_ALLOC_B] &
                    ctrl_r[cis_pkg::CTRL_ALLOC_D];
   wire mode_ok = (mode >= cis_pkg::MODE_ZERO) &&
                  (mode <= cis_pkg::MODE_TORQUE);
   wire active = allocated && mode_ok;
   wire sel_a = ~i_speed_select_a_n;
   wire sel_b = ~i_speed_select_b_n;
   wire dir_on = ~i_direction_select_n;
   wire sample_now = (samp_cnt_r == 32'(SAMPLE_CYCLES - 1));
   wire preset_sel = (sel_r != 2'b00);
   wire [15:0] preset = (sel_r == 2'b01) ? spd1_r :
                        (sel_r == 2'b11) ? spd2_r : spd3_r;
   wire [15:0] target_raw = preset_sel ? preset : 16'h0000;
   wire [15:0] target = (target_raw > max_r) ? max_r :
                        target_raw;
   wire [1:0] src_nxt = !active ? 2'(cis_pkg::SRC_ANALOG) :
      preset_sel ? 2'(cis_pkg::SRC_PRESET) :
      (mode == cis_pkg::MODE_ZERO) ? 2'(cis_pkg::SRC_ZERO) :
      (mode == cis_pkg::MODE_PULSE) ? 2'(cis_pkg::SRC_PULSE) :
      2'(cis_pkg::SRC_ANALOG);
   // ramp only for the preset source with mode 5
   wire ramp_ok = active && (mode == cis_pkg::MODE_PULSE) &&
                  (src_nxt != 2'(cis_pkg::SRC_PULSE));
   wire no_ramp = !ramp_ok ||
      ((accel_r == 16'h0000) && (decel_r == 16'h0000));
   // step per ms tick = max / time_ms; one step per ms, time quantised to ms
   wire [15:0] up_step = (accel_r == 16'h0000) ? max_r :
      ((max_r / accel_r) == 16'h0000 ? 16'h0001 : max_r / accel_r);
   wire [15:0] dn_step = (decel_r == 16'h0000) ? max_r :
      ((max_r / decel_r) == 16'h0000 ? 16'h0001 : max_r / decel_r);
   wire ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
   wire [16:0] up_sum = {1'b0, ref_r} + {1'b0, up_step};
   wire [15:0] ref_up = (up_sum > {1'b0, target}) ? target : up_sum[15:0];
   wire [15:0] ref_dn = (ref_r < target + dn_step) ? target :
                        ref_r - dn_step;
   wire [15:0] ref_nxt = no_ramp ? target :
      !ms_tick ? ref_r :
      (ref_r < target) ? ref_up :
      (ref_r > target) ? ref_dn : ref_r;
   // leaving a preset while turning blocks pulses until done
   wire enter_pulse = (src_r == 2'(cis_pkg::SRC_PRESET)) &&
      (src_nxt == 2'(cis_pkg::SRC_PULSE)) && (ref_r != 16'h0000);
   wire done = ~i_positioning_done_n;
   wire hold_nxt = enter_pulse ? 1'b1 : (done ? 1'b0 : hold_pulse_r);
   wire [15:0] rd_mux =
      (i_addr == cis_pkg::ADDR_ACCEL) ? accel_r :
      (i_addr == cis_pkg::ADDR_DECEL) ? decel_r :
      (i_addr == cis_pkg::ADDR_SPD1) ? spd1_r :
      (i_addr == cis_pkg::ADDR_SPD2) ? spd2_r :
      (i_addr == cis_pkg::ADDR_SPD3) ? spd3_r :
      (i_addr == cis_pkg::ADDR_CTRL) ? {9'h000, ctrl_r} :
      (i_addr == cis_pkg::ADDR_MAXSPD) ? max_r :
      (i_addr == cis_pkg::ADDR_STAT) ?
         {10'h000, hold_pulse_r, rev_r, src_r, sel_r} :
      (i_addr == cis_pkg::ADDR_REF) ? ref_r : 16'h0000;
   wire [15:0] wclip = (i_wdata > cis_pkg::SET_LIMIT) ? cis_pkg::SET_LIMIT :
                       i_wdata;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         accel_r <= cis_pkg::RST_ACCEL;
         decel_r <= cis_pkg::RST_DECEL;
         spd1_r <= cis_pkg::RST_SPD1;
         spd2_r <= cis_pkg::RST_SPD2;
         spd3_r <= cis_pkg::RST_SPD3;
         max_r <= cis_pkg::RST_MAXSPD;
         ctrl_r <= {3'h0, cis_pkg::RST_MODE};
      end
      else if (i_wr)
      begin
         if (i_addr == cis_pkg::ADDR_ACCEL) accel_r <= wclip;
         if (i_addr == cis_pkg::ADDR_DECEL) decel_r <= wclip;
         if (i_addr == cis_pkg::ADDR_SPD1) spd1_r <= wclip;
         if (i_addr == cis_pkg::ADDR_SPD2) spd2_r <= wclip;
         if (i_addr == cis_pkg::ADDR_SPD3) spd3_r <= wclip;
         if (i_addr == cis_pkg::ADDR_CTRL) ctrl_r <= i_wdata[6:0];
         if (i_addr == cis_pkg::ADDR_MAXSPD) max_r <= wclip;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         rdata_r <= 16'h0000;
         samp_cnt_r <= 32'h0000_0000;
         ms_cnt_r <= 32'h0000_0000;
         sel_r <= 2'b00;
         ref_r <= 16'h0000;
         rev_r <= 1'b0;
         src_r <= 2'(cis_pkg::SRC_ANALOG);
         hold_pulse_r <= 1'b0;
         pulse_r <= 1'b0;
         alt_r <= '0;
      end
      else
      begin
         rdata_r <= i_rd ? rd_mux : 16'h0000;
         samp_cnt_r <= sample_now ? 32'h0000_0000 : samp_cnt_r + 32'h1;
         ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h1;
         if (sample_now)
            sel_r <= active ? {sel_a, sel_b} : 2'b00;
         ref_r <= ref_nxt;
         if (active && preset_sel)
            rev_r <= dir_on;
         src_r <= src_nxt;
         hold_pulse_r <= hold_nxt;
         pulse_r <= i_ref_pulse && (src_nxt == 2'(cis_pkg::SRC_PULSE)) &&
                    !hold_nxt;
         alt_r.fwd_limit <= !active && sel_a;
         alt_r.rev_limit <= !active && sel_b;
         alt_r.alt_func <= !active && dir_on;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   assign o_rdata = rdata_r;
   assign o_speed_ref = ref_r;
   assign o_reverse = rev_r;
   assign o_source = src_r;
   assign o_ref_pulse = pulse_r;
   assign o_fwd_limit_en = alt_r.fwd_limit;
   assign o_rev_limit_en = alt_r.rev_limit;
   assign o_alt_func = alt_r.alt_func;
   ////////////////////////////////////////////////////////////////////////
   passthru_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      no_ramp |=> ref_r == $past(target))
      else $error("speed reference not passed through");
   ramp_bound_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!no_ramp && !ms_tick) |=> $stable(ref_r))
      else $error("ramp moved between ticks");
   limit_max_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ref_r <= max_r || $changed(max_r) || !$past(i_resetn))
      else $error("speed reference above maximum");
   pulse_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      hold_pulse_r |-> !o_ref_pulse)
      else $error("pulse passed while held");
   zero_mode_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (active && !preset_sel && mode == cis_pkg::MODE_ZERO)
      |=> src_r == 2'(cis_pkg::SRC_ZERO))
      else $error("mode 3 not zero source");
   dir_follow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (active && preset_sel) |=> rev_r == $past(dir_on))
      else $error("direction not followed");
   limit_reuse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      active |=> !o_fwd_limit_en && !o_rev_limit_en)
      else $error("torque limit active during speed select");
   alloc_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !allocated |=> sel_r == 2'b00 || !$past(sample_now))
      else $error("selection used without allocation");
   ////////////////////////////////////////////////////////////////////////
   // preset decode, checked on the clamped target only where the preset is within max_r
   preset_one_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (sel_r == 2'b01 && spd1_r <= max_r) |-> target == spd1_r)
      else $error("preset one not selected");
   preset_two_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (sel_r == 2'b11 && spd2_r <= max_r) |-> target == spd2_r)
      else $error("preset two not selected");
   preset_three_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (sel_r == 2'b10 && spd3_r <= max_r) |-> target == spd3_r)
      else $error("preset three not selected");
   idle_target_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      sel_r == 2'b00 |-> target == 16'h0000)
      else $error("target not zero with no preset");
   preset_src_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (active && preset_sel) |=> src_r == 2'(cis_pkg::SRC_PRESET))
      else $error("preset source not shown");
   pulse_mode_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (active && !preset_sel && mode == cis_pkg::MODE_PULSE)
      |=> src_r == 2'(cis_pkg::SRC_PULSE))
      else $error("mode 5 not pulse source");
   // torque reference arrives on the analog path, so it shares that code
   analog_mode_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (active && !preset_sel && (mode == cis_pkg::MODE_ANALOG ||
      mode == cis_pkg::MODE_TORQUE)) |=> src_r == 2'(cis_pkg::SRC_ANALOG))
      else $error("mode 4 or 6 not analog source");
   zero_ref_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (active && !preset_sel && mode == cis_pkg::MODE_ZERO)
      |=> ref_r == 16'h0000)
      else $error("mode 3 reference not zero");
   mode_gate_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !mode_ok |=> src_r == 2'(cis_pkg::SRC_ANALOG))
      else $error("presets used outside modes 3 to 6");
   alloc_src_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !allocated |=> src_r == 2'(cis_pkg::SRC_ANALOG))
      else $error("source changed without allocation");
   inactive_sel_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (!active && sample_now) |=> sel_r == 2'b00)
      else $error("selects sampled while inactive");
   ////////////////////////////////////////////////////////////////////////
   // sampling: one fresh look per period bounds the select latency
   sample_take_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (active && sample_now) |=>
      sel_r[1] == $past(sel_a) && sel_r[0] == $past(sel_b))
      else $error("selects not sampled");
   sample_hold_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !sample_now |=> $stable(sel_r))
      else $error("selects moved between samples");
   sample_period_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      samp_cnt_r <= 32'(SAMPLE_CYCLES - 1))
      else $error("sample counter overran");
   dir_keep_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !(active && preset_sel) |=> $stable(rev_r))
      else $error("direction moved without preset");
   ////////////////////////////////////////////////////////////////////////
   // input reuse while the function is off
   alt_fwd_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !active |=> o_fwd_limit_en == $past(sel_a))
      else $error("forward limit not following input");
   alt_rev_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !active |=> o_rev_limit_en == $past(sel_b))
      else $error("reverse limit not following input");
   alt_dir_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !active |=> o_alt_func == $past(dir_on))
      else $error("alternative function not following input");
   alt_quiet_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      active |=> !o_alt_func)
      else $error("alternative function active during selection");
   ////////////////////////////////////////////////////////////////////////
   // ramp shape: monotonic toward the target, never past it
   ramp_up_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (!no_ramp && ms_tick && ref_r < target) |=>
      ref_r > $past(ref_r) && ref_r <= $past(target))
      else $error("ramp up step wrong");
   ramp_dn_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (!no_ramp && ms_tick && ref_r > target) |=>
      ref_r < $past(ref_r) && ref_r >= $past(target))
      else $error("ramp down step wrong");
   ms_period_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      ms_cnt_r <= 32'(MS_CYCLES - 1))
      else $error("ms counter overran");
   ramp_zero_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (accel_r == 16'h0000 && decel_r == 16'h0000)
      |=> ref_r == $past(target))
      else $error("zero ramp times still ramped");
   ramp_pulse_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      src_nxt == 2'(cis_pkg::SRC_PULSE) |=> ref_r == $past(target))
      else $error("ramp applied on pulse source");
   target_cap_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      target <= max_r)
      else $error("target above maximum speed");
   ////////////////////////////////////////////////////////////////////////
   // settings stay inside their documented range
   accel_range_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      accel_r <= cis_pkg::SET_LIMIT)
      else $error("accel time out of range");
   decel_range_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      decel_r <= cis_pkg::SET_LIMIT)
      else $error("decel time out of range");
   spd_range_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      spd1_r <= cis_pkg::SET_LIMIT && spd2_r <= cis_pkg::SET_LIMIT &&
      spd3_r <= cis_pkg::SET_LIMIT)
      else $error("preset speed out of range");
   ////////////////////////////////////////////////////////////////////////
   // pulse handover
   hold_set_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      enter_pulse |=> hold_pulse_r)
      else $error("pulse hold not set");
   hold_clear_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (!enter_pulse && done) |=> !hold_pulse_r)
      else $error("pulse hold not cleared by done");
   pulse_src_a: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      o_ref_pulse |-> src_r == 2'(cis_pkg::SRC_PULSE))
      else $error("pulse passed outside pulse source");
endmodule

// ### design/cis_pkg.sv
// Behaviour
// - accel time in ms, 0..10000, default 0, standstill to max speed.
// - decel time in ms, 0..10000, default 0, max speed to standstill.
// - internal speed reference follows ramp settings instead of stepping.
// - both ramp times zero: selected reference passes straight through.
// - both selects off: mode 3 zero, 4 analog, 5 pulse, 6 torque.
// - modes 3..6: B only preset one, both preset two, A only three.
// - preset selected: direction input 0 forward, 1 reverse.
// - contact inputs active low; high reads off, low reads on.
// - function unused: selects become forward/reverse torque limit enables.
// - function unused: direction input is its alternative control function.
// - function enabled only when all three inputs are allocated.
// - ramp only in contact selection with mode 5, never on pulse source.
// - after preset to pulse while running, ignore pulses until done.
// - select inputs take effect within 2 ms.
// - three presets 0..10000 rpm, defaults 100, 200, 300.
// - preset above motor maximum speed is limited to the maximum.
package cis_pkg;
   localparam logic [3:0] ADDR_ACCEL = 4'h0;
   localparam logic [3:0] ADDR_DECEL = 4'h1;
   localparam logic [3:0] ADDR_SPD1 = 4'h2;
   localparam logic [3:0] ADDR_SPD2 = 4'h3;
   localparam logic [3:0] ADDR_SPD3 = 4'h4;
   localparam logic [3:0] ADDR_CTRL = 4'h5;
   localparam logic [3:0] ADDR_MAXSPD = 4'h6;
   localparam logic [3:0] ADDR_STAT = 4'h7;
   localparam logic [3:0] ADDR_REF = 4'h8;
   localparam logic [15:0] RST_ACCEL = 16'h0000;
   localparam logic [15:0] RST_DECEL = 16'h0000;
   localparam logic [15:0] RST_SPD1 = 16'h0064;
   localparam logic [15:0] RST_SPD2 = 16'h00c8;
   localparam logic [15:0] RST_SPD3 = 16'h012c;
   localparam logic [15:0] RST_MAXSPD = 16'h0bb8;
   localparam logic [15:0] SET_LIMIT = 16'h2710;
   localparam logic [3:0] RST_MODE = 4'h0;
   // ctrl register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ALLOC_A = 4;
   localparam int CTRL_ALLOC_B = 5;
   localparam int CTRL_ALLOC_D = 6;
   localparam logic [3:0] MODE_ZERO = 4'h3;
   localparam logic [3:0] MODE_ANALOG = 4'h4;
   localparam logic [3:0] MODE_PULSE = 4'h5;
   localparam logic [3:0] MODE_TORQUE = 4'h6;
   localparam int CLK_HZ = 10000000;
   localparam int SAMPLE_MS = 1;
   localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   typedef enum logic [1:0] {SRC_ZERO, SRC_PRESET, SRC_ANALOG, SRC_PULSE}
      cis_src_e;
   typedef struct packed {
      logic fwd_limit;
      logic rev_limit;
      logic alt_func;
   } cis_alt_s;
endpackage

// ### testbench/cis_host_model.sv
`timescale 1ns/10ps
module cis_host_model (
   input wire logic i_clk, // system clock
   input wire logic i_sel_a, // select A wanted, 1 = on
   input wire logic i_sel_b, // select B wanted, 1 = on
   input wire logic i_rev, // reverse wanted, 1 = on
   input wire logic i_pulse_req, // host wants to send pulses
   input wire logic i_early, // send pulses before done is seen
   input wire logic i_positioning_done_n, // done from device, low = done
   output logic o_speed_select_a_n, // contact A
   output logic o_speed_select_b_n, // contact B
   output logic o_direction_select_n, // contact D
   output logic o_ref_pulse // reference pulse to device
);
   logic done_seen_r = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   // contacts close to ground when on
   assign o_speed_select_a_n = ~i_sel_a;
   assign o_speed_select_b_n = ~i_sel_b;
   assign o_direction_select_n = ~i_rev;
   // a new preset run forgets any earlier done report
   always_ff @(posedge i_clk)
   begin
      if (i_sel_a | i_sel_b)
         done_seen_r <= 1'b0;
      else if (!i_positioning_done_n)
         done_seen_r <= 1'b1;
   end
   // early is only for provoking the device into ignoring pulses
   assign o_ref_pulse = i_pulse_req & (done_seen_r | i_early);
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000, o_rdata, o_speed_ref;
   logic sa = 1'b0, sb = 1'b0, sd = 1'b0, preq = 1'b0, early = 1'b0;
   logic done_n = 1'b1, a_n, b_n, d_n, pulse, o_reverse, o_ref_pulse;
   logic fwd, rev, alt;
   logic [1:0] o_source;
   int num_errors = 0, num_checks = 0, cyc = 0, npulse = 0;
   initial forever #50 i_clk = ~i_clk;
   // short sample and ms counts keep ramps to a few dozen cycles
   cis_speed_select #(.SAMPLE_CYCLES(4), .MS_CYCLES(4)) cis_speed_select_inst (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_speed_select_a_n(a_n), .i_speed_select_b_n(b_n),
      .i_direction_select_n(d_n), .i_ref_pulse(pulse),
      .i_positioning_done_n(done_n), .o_speed_ref(o_speed_ref),
      .o_reverse(o_reverse), .o_source(o_source),
      .o_ref_pulse(o_ref_pulse), .o_fwd_limit_en(fwd),
      .o_rev_limit_en(rev), .o_alt_func(alt));
   cis_host_model cis_host_model_inst (
      .i_clk(i_clk), .i_sel_a(sa), .i_sel_b(sb), .i_rev(sd),
      .i_pulse_req(preq), .i_early(early), .i_positioning_done_n(done_n),
      .o_speed_select_a_n(a_n), .o_speed_select_b_n(b_n),
      .o_direction_select_n(d_n), .o_ref_pulse(pulse));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 check(o_rdata, e);
   endtask
   task automatic sel(input logic a, input logic b, input logic d);
      @(posedge i_clk);
      sa <= a;
      sb <= b;
      sd <= d;
      repeat (8) @(posedge i_clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk)
   begin
      npulse += (o_ref_pulse === 1'b1) ? 1 : 0;
      cyc++;
      if (cyc == 2000)
      begin
         num_errors++;
         summarize();
      end
   end
   initial
   begin
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(cis_pkg::ADDR_ACCEL, cis_pkg::RST_ACCEL);
      rd(cis_pkg::ADDR_DECEL, cis_pkg::RST_DECEL);
      rd(cis_pkg::ADDR_SPD1, 16'h0064);
      rd(cis_pkg::ADDR_SPD2, 16'h00c8);
      rd(cis_pkg::ADDR_SPD3, 16'h012c);
      rd(4'hf, 16'h0000);
      wr(cis_pkg::ADDR_DECEL, 16'hffff);
      rd(cis_pkg::ADDR_DECEL, 16'h2710);
      wr(cis_pkg::ADDR_ACCEL, 16'h000a);
      $display("registers done");
      wr(cis_pkg::ADDR_CTRL, 16'h0073);
      sel(1'b0, 1'b0, 1'b0);
      check(o_speed_ref, 16'h0000);
      check(16'(o_source), 16'(cis_pkg::SRC_ZERO));
      sel(1'b0, 1'b1, 1'b0);
      check(o_speed_ref, 16'h0064);
      check(16'(o_reverse), 16'h0000);
      sel(1'b1, 1'b1, 1'b1);
      check(o_speed_ref, 16'h00c8);
      check(16'(o_reverse), 16'h0001);
      sel(1'b1, 1'b0, 1'b0);
      check(o_speed_ref, 16'h012c);
      $display("mode three presets done");
      wr(cis_pkg::ADDR_CTRL, 16'h0074);
      sel(1'b0, 1'b0, 1'b0);
      check(16'(o_source), 16'(cis_pkg::SRC_ANALOG));
      wr(cis_pkg::ADDR_CTRL, 16'h0075);
      sel(1'b0, 1'b0, 1'b0);
      check(16'(o_source), 16'(cis_pkg::SRC_PULSE));
      wr(cis_pkg::ADDR_CTRL, 16'h0076);
      sel(1'b0, 1'b0, 1'b0);
      check(16'(o_source), 16'(cis_pkg::SRC_ANALOG));
      wr(cis_pkg::ADDR_CTRL, 16'h0033);
      sel(1'b1, 1'b0, 1'b1);
      check(16'({fwd, rev, alt}), 16'h0005);
      wr(cis_pkg::ADDR_CTRL, 16'h0070);
      sel(1'b0, 1'b1, 1'b0);
      check(16'({fwd, rev, alt}), 16'h0002);
      sel(1'b0, 1'b0, 1'b1);
      check(16'({fwd, rev, alt}), 16'h0001);
      $display("modes and input reuse done");
      wr(cis_pkg::ADDR_MAXSPD, 16'h0096);
      wr(cis_pkg::ADDR_CTRL, 16'h0073);
      sel(1'b1, 1'b1, 1'b0);
      check(o_speed_ref, 16'h0096);
      wr(cis_pkg::ADDR_MAXSPD, cis_pkg::RST_MAXSPD);
      wr(cis_pkg::ADDR_SPD3, 16'h07d0);
      wr(cis_pkg::ADDR_CTRL, 16'h0075);
      sel(1'b1, 1'b0, 1'b0);
      check(16'(o_speed_ref < 16'h07d0), 16'h0001);
      repeat (40) @(posedge i_clk);
      #1 check(o_speed_ref, 16'h07d0);
      rd(cis_pkg::ADDR_REF, 16'h07d0);
      $display("limit and ramp done");
      // reference is still nonzero in the cycle the source flips to pulses
      @(posedge i_clk);
      early <= 1'b1;
      sel(1'b0, 1'b0, 1'b0);
      @(posedge i_clk);
      preq <= 1'b1;
      repeat (8) @(posedge i_clk);
      #1 check(16'(npulse), 16'h0000);
      @(posedge i_clk);
      early <= 1'b0;
      done_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      #1 check(16'(npulse > 0), 16'h0001);
      $display("pulse handover done");
      summarize();
   end
endmodule
